// ==== hw/psq_sequencer.v ====
// proximity measurement sequencer with AHB-Lite register slave
//
// How it works
// - host command starts one measurement
// - autonomous mode repeats at programmed interval
// - one conversion per enabled channel, max three
// - three LED drivers, per-conversion selection
// - reset default: one distinct LED each
// - selection may reorder or enable all LEDs
// - each channel compared to own threshold
// - threshold mode interrupts only on crossing
// - alternatively interrupt after full set completes
// - each LED current separately writable
// - saturated conversion records overflow in response
// - overflowed channel data reads saturation value
// - in-range conversion restores measured data
// - overflow held until no-operation command arrives
// - commands still executed while overflow set
// - interrupt pin open-drain, driven low
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "psq_defines.vh"

module psq_sequencer
(
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // adc link, on the adc's own clock
  input wire adc_clk,
  input wire adc_done,
  input wire adc_ovf,
  input wire [11:0] adc_data,
  output reg adc_start,
  output reg [1:0] adc_chan,
  // led drivers
  output reg [2:0] led_on,
  output reg [3:0] led_cur0,
  output reg [3:0] led_cur1,
  output reg [3:0] led_cur2,
  // open-drain interrupt pin
  input wire int_in,
  output wire int_out,
  output wire int_oe
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SCAN = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam ST_DONE = 2'h3;

  // ==========================================
  // helpers
  // pick the 3-bit led set of one conversion
  function [2:0] led_field;
    input [11:0] sel;
    input [1:0] ch;
    begin
      led_field = 3'h0;
      if (ch == 2'h0)
        led_field = sel[2:0];
      else if (ch == 2'h1)
        led_field = sel[6:4];
      else if (ch == 2'h2)
        led_field = sel[10:8];
    end
  endfunction

  // pick a 4-bit current field
  function [3:0] cur_field;
    input [11:0] cur;
    input [1:0] idx;
    begin
      cur_field = cur[3:0];
      if (idx == 2'h1)
        cur_field = cur[7:4];
      else if (idx == 2'h2)
        cur_field = cur[11:8];
    end
  endfunction

  // ==========================================
  // registers
  reg [4:0] cfg_r;
  reg [11:0] ledsel_r;
  reg [11:0] ledcur_r;
  reg [15:0] rate_r;
  reg [11:0] th0_r;
  reg [11:0] th1_r;
  reg [11:0] th2_r;
  reg [11:0] data0_r;
  reg [11:0] data1_r;
  reg [11:0] data2_r;
  reg [11:0] alsdata_r;
  reg resp_ovf_r;
  reg [2:0] istat_r;
  reg [2:0] ien_r;
  reg [2:0] above_r;
  reg auto_r;
  reg pend_ps_r;
  reg pend_als_r;
  reg [1:0] state_r;
  reg [1:0] ch_r;
  reg set_ovf_r;
  reg [2:0] ev_r;

  // ==========================================
  // ahb-lite slave: zero wait states, always okay
  reg wr_pend_r;
  reg [5:0] wr_addr_r;
  wire addr_ok = hsel && hready && htrans[1];
  wire wr_cmd = wr_pend_r && (wr_addr_r == `PSQ_A_CMD);
  wire wr_clr = wr_pend_r && (wr_addr_r == `PSQ_A_ICLR);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture and read data
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 6'h00;
      hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr_r <= haddr[5:0];
      if (addr_ok && !hwrite)
      begin
        if (haddr[5:0] == `PSQ_A_CFG)
          hrdata <= {27'h0, cfg_r};
        else if (haddr[5:0] == `PSQ_A_LEDSEL)
          hrdata <= {20'h0, ledsel_r};
        else if (haddr[5:0] == `PSQ_A_LEDCUR)
          hrdata <= {20'h0, ledcur_r};
        else if (haddr[5:0] == `PSQ_A_RATE)
          hrdata <= {16'h0, rate_r};
        else if (haddr[5:0] == `PSQ_A_TH0)
          hrdata <= {20'h0, th0_r};
        else if (haddr[5:0] == `PSQ_A_TH1)
          hrdata <= {20'h0, th1_r};
        else if (haddr[5:0] == `PSQ_A_TH2)
          hrdata <= {20'h0, th2_r};
        else if (haddr[5:0] == `PSQ_A_DATA0)
          hrdata <= {20'h0, data0_r};
        else if (haddr[5:0] == `PSQ_A_DATA1)
          hrdata <= {20'h0, data1_r};
        else if (haddr[5:0] == `PSQ_A_DATA2)
          hrdata <= {20'h0, data2_r};
        else if (haddr[5:0] == `PSQ_A_ALSDATA)
          hrdata <= {20'h0, alsdata_r};
        else if (haddr[5:0] == `PSQ_A_RESP)
          hrdata <= {27'h0, auto_r, state_r, resp_ovf_r, 1'b0} >> 1;
        else if (haddr[5:0] == `PSQ_A_ISTAT)
          hrdata <= {29'h0, istat_r};
        else if (haddr[5:0] == `PSQ_A_IEN)
          hrdata <= {29'h0, ien_r};
        else
          hrdata <= 32'h00000000;
      end
    end
  end

  // configuration writes in the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_r <= `PSQ_RST_CFG;
      ledsel_r <= `PSQ_RST_LEDSEL;
      ledcur_r <= `PSQ_RST_LEDCUR;
      rate_r <= `PSQ_RST_RATE;
      th0_r <= `PSQ_RST_TH;
      th1_r <= `PSQ_RST_TH;
      th2_r <= `PSQ_RST_TH;
      ien_r <= 3'h0;
    end
    else if (wr_pend_r)
    begin
      if (wr_addr_r == `PSQ_A_CFG)
        cfg_r <= hwdata[4:0];
      else if (wr_addr_r == `PSQ_A_LEDSEL)
        ledsel_r <= {1'b0, hwdata[10:8], 1'b0, hwdata[6:4], 1'b0, hwdata[2:0]};
      else if (wr_addr_r == `PSQ_A_LEDCUR)
        ledcur_r <= hwdata[11:0];
      else if (wr_addr_r == `PSQ_A_RATE)
        rate_r <= hwdata[15:0];
      else if (wr_addr_r == `PSQ_A_TH0)
        th0_r <= hwdata[11:0];
      else if (wr_addr_r == `PSQ_A_TH1)
        th1_r <= hwdata[11:0];
      else if (wr_addr_r == `PSQ_A_TH2)
        th2_r <= hwdata[11:0];
      else if (wr_addr_r == `PSQ_A_IEN)
        ien_r <= hwdata[2:0];
    end
  end

  // led current outputs follow their settings at run time
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      led_cur0 <= 4'h0;
      led_cur1 <= 4'h0;
      led_cur2 <= 4'h0;
    end
    else
    begin
      led_cur0 <= cur_field(ledcur_r, 2'h0);
      led_cur1 <= cur_field(ledcur_r, 2'h1);
      led_cur2 <= cur_field(ledcur_r, 2'h2);
    end
  end

  // ==========================================
  // adc link: synchronise pins, act on adc_clk rising edges
  reg [1:0] aclk_s;
  reg [1:0] adone_s;
  reg [1:0] aovf_s;
  reg [11:0] adat_s0;
  reg [11:0] adat_s1;
  reg aclk_d;
  wire aclk_rise = aclk_s[1] && !aclk_d;
  wire conv_done = (state_r == ST_CONV) && aclk_rise && adone_s[1];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aclk_s <= 2'h0;
      adone_s <= 2'h0;
      aovf_s <= 2'h0;
      adat_s0 <= 12'h000;
      adat_s1 <= 12'h000;
      aclk_d <= 1'b0;
    end
    else
    begin
      aclk_s <= {aclk_s[0], adc_clk};
      adone_s <= {adone_s[0], adc_done};
      aovf_s <= {aovf_s[0], adc_ovf};
      adat_s0 <= adc_data;
      adat_s1 <= adat_s0;
      aclk_d <= aclk_s[1];
    end
  end

  // ==========================================
  // interval timer: 1 us tick, interval in ticks
  reg [5:0] pre_r;
  reg [15:0] ivl_r;
  wire tick = (pre_r == `PSQ_TICK_CYC - 1);
  wire auto_due = auto_r && tick && (ivl_r >= rate_r);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_r <= 6'h00;
      ivl_r <= 16'h0000;
    end
    else
    begin
      pre_r <= tick ? 6'h00 : pre_r + 6'h01;
      if (!auto_r || auto_due)
        ivl_r <= 16'h0000;
      else if (tick)
        ivl_r <= ivl_r + 16'h0001;
    end
  end

  // ==========================================
  // command decode and pending requests
  wire [7:0] cmd = hwdata[7:0];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      auto_r <= 1'b0;
      pend_ps_r <= 1'b0;
      pend_als_r <= 1'b0;
    end
    else
    begin
      // commands run regardless of the overflow flag
      if (wr_cmd && cmd == `PSQ_CMD_AUTO_GO)
        auto_r <= 1'b1;
      else if (wr_cmd && cmd == `PSQ_CMD_AUTO_STOP)
        auto_r <= 1'b0;
      if ((wr_cmd && cmd == `PSQ_CMD_PS_FORCE) || auto_due)
        pend_ps_r <= 1'b1;
      else if (state_r == ST_IDLE)
        pend_ps_r <= 1'b0;
      if ((wr_cmd && cmd == `PSQ_CMD_ALS_FORCE) || (auto_due && cfg_r[`PSQ_CFG_ALSEN]))
        pend_als_r <= 1'b1;
      else if (state_r == ST_IDLE && !pend_ps_r)
        pend_als_r <= 1'b0;
    end
  end

  // ==========================================
  // measurement state machine
  reg als_run_r;
  wire [11:0] th_cur = (ch_r == 2'h0) ? th0_r : ((ch_r == 2'h1) ? th1_r : th2_r);
  wire [11:0] result = aovf_s[1] ? `PSQ_SAT : adat_s1;
  wire now_above = result > th_cur;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_IDLE;
      ch_r <= 2'h0;
      als_run_r <= 1'b0;
      adc_start <= 1'b0;
      adc_chan <= 2'h0;
      led_on <= 3'h0;
      data0_r <= 12'h000;
      data1_r <= 12'h000;
      data2_r <= 12'h000;
      alsdata_r <= 12'h000;
      above_r <= 3'h0;
      set_ovf_r <= 1'b0;
      ev_r <= 3'h0;
    end
    else
    begin
      ev_r <= 3'h0;
      set_ovf_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          ch_r <= 2'h0;
          if (pend_ps_r)
          begin
            als_run_r <= 1'b0;
            state_r <= ST_SCAN;
          end
          else if (pend_als_r)
          begin
            als_run_r <= 1'b1;
            ch_r <= `PSQ_ALS_CH;
            state_r <= ST_SCAN;
          end
        end
        ST_SCAN:
        begin
          // a new start waits until the adc has dropped done of the last one
          if (!als_run_r && ch_r == `PSQ_ALS_CH)
            state_r <= ST_DONE;
          else if (!als_run_r && !cfg_r[ch_r])
            ch_r <= ch_r + 2'h1;
          else if (adone_s[1])
            state_r <= ST_SCAN;
          else if (als_run_r)
          begin
            adc_chan <= `PSQ_ALS_CH;
            adc_start <= 1'b1;
            state_r <= ST_CONV;
          end
          else
          begin
            adc_chan <= ch_r;
            led_on <= led_field(ledsel_r, ch_r);
            adc_start <= 1'b1;
            state_r <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (conv_done)
          begin
            adc_start <= 1'b0;
            led_on <= 3'h0;
            set_ovf_r <= aovf_s[1];
            if (als_run_r)
            begin
              alsdata_r <= result;
              ev_r[`PSQ_EV_ALSDONE] <= 1'b1;
              state_r <= ST_IDLE;
            end
            else
            begin
              if (ch_r == 2'h0)
                data0_r <= result;
              else if (ch_r == 2'h1)
                data1_r <= result;
              else
                data2_r <= result;
              above_r[ch_r] <= now_above;
              if (cfg_r[`PSQ_CFG_THMODE] && (now_above != above_r[ch_r]))
                ev_r[`PSQ_EV_PSCROSS] <= 1'b1;
              ch_r <= ch_r + 2'h1;
              state_r <= ST_SCAN;
            end
          end
        end
        ST_DONE:
        begin
          if (!cfg_r[`PSQ_CFG_THMODE])
            ev_r[`PSQ_EV_PSDONE] <= 1'b1;
          state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // response overflow: sticky until no-operation, set wins
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      resp_ovf_r <= 1'b0;
    else if (set_ovf_r)
      resp_ovf_r <= 1'b1;
    else if (wr_cmd && cmd == `PSQ_CMD_NOP)
      resp_ovf_r <= 1'b0;
  end

  // ==========================================
  // interrupt status: sticky, write-one clear, set wins
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      istat_r <= 3'h0;
    else
      istat_r <= (istat_r & ~(wr_clr ? hwdata[2:0] : 3'h0)) | ev_r;
  end

  // open drain: drive low while an enabled event is pending
  assign int_out = 1'b0;
  assign int_oe = |(istat_r & ien_r);

endmodule

// ==== common/psq_defines.vh ====
// register map, field layout, reset values and timing constants of the proximity sequencer
`ifndef PSQ_DEFINES_VH
`define PSQ_DEFINES_VH

// ==========================================
// register byte offsets
`define PSQ_A_CMD 6'h00
`define PSQ_A_CFG 6'h04
`define PSQ_A_LEDSEL 6'h08
`define PSQ_A_LEDCUR 6'h0C
`define PSQ_A_RATE 6'h10
`define PSQ_A_TH0 6'h14
`define PSQ_A_TH1 6'h18
`define PSQ_A_TH2 6'h1C
`define PSQ_A_DATA0 6'h20
`define PSQ_A_DATA1 6'h24
`define PSQ_A_DATA2 6'h28
`define PSQ_A_ALSDATA 6'h2C
`define PSQ_A_RESP 6'h30
`define PSQ_A_ISTAT 6'h34
`define PSQ_A_IEN 6'h38
`define PSQ_A_ICLR 6'h3C

// ==========================================
// command codes
`define PSQ_CMD_NOP 8'h00
`define PSQ_CMD_PS_FORCE 8'h01
`define PSQ_CMD_ALS_FORCE 8'h02
`define PSQ_CMD_AUTO_GO 8'h03
`define PSQ_CMD_AUTO_STOP 8'h04

// ==========================================
// field positions
`define PSQ_CFG_CHEN 2:0
`define PSQ_CFG_THMODE 3
`define PSQ_CFG_ALSEN 4
`define PSQ_RESP_OVF 0
`define PSQ_EV_PSDONE 0
`define PSQ_EV_PSCROSS 1
`define PSQ_EV_ALSDONE 2

// ==========================================
// reset values
`define PSQ_RST_CFG 5'h01
`define PSQ_RST_LEDSEL 12'h421
`define PSQ_RST_LEDCUR 12'h111
`define PSQ_RST_RATE 16'h0000
`define PSQ_RST_TH 12'h000

// ==========================================
// sizes and timing
`define PSQ_ADC_W 12
`define PSQ_SAT 12'hFFF
`define PSQ_ALS_CH 2'h3
`define PSQ_CLK_NS 25
`define PSQ_TICK_NS 1000
`define PSQ_TICK_CYC (`PSQ_TICK_NS / `PSQ_CLK_NS)

`endif

// ==== bench/psq_assertions.sv ====
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`include "psq_defines.vh"

module psq_assertions
(
  // clock, reset, bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  // adc link and pins
  input wire adc_clk,
  input wire adc_done,
  input wire adc_start,
  input wire [1:0] adc_chan,
  input wire [2:0] led_on,
  input wire [3:0] led_cur0,
  input wire [3:0] led_cur1,
  input wire [3:0] led_cur2,
  input wire int_out,
  input wire int_oe
);
  // write address phase taken at this edge
  wire wa = hsel && hready && htrans[1] && hwrite;
  wire [5:0] a = haddr[5:0];

  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ==========
  // checks
  int_low_a: assert property (int_oe |-> !int_out)
    else $error("int pin not low");
  int_hold_a: assert property ($fell(int_oe) |->
    $past(wa && (a == `PSQ_A_ICLR || a == `PSQ_A_IEN), 2))
    else $error("int dropped unasked");
  led_idle_a: assert property (!adc_start |-> led_on == 3'h0)
    else $error("led on when idle");
  als_dark_a: assert property (adc_start && adc_chan == `PSQ_ALS_CH |-> led_on == 3'h0)
    else $error("led on in ambient");
  conv_hold_a: assert property (adc_start && $past(adc_start) |->
    $stable(adc_chan) && $stable(led_on))
    else $error("conversion moved");
  conv_end_a: assert property (adc_start && adc_done && $rose(adc_clk) |-> ##[1:8] !adc_start)
    else $error("conversion not closed");
  conv_gap_a: assert property ($fell(adc_start) |-> !adc_start [*2])
    else $error("conversions too close");
  force_go_a: assert property ($past(wa && a == `PSQ_A_CMD) && !adc_start &&
    hwdata[7:0] == `PSQ_CMD_PS_FORCE |-> ##[1:8] adc_start)
    else $error("force not started");
  cur_copy_a: assert property (wa && a == `PSQ_A_LEDCUR |->
    ##3 {led_cur2, led_cur1, led_cur0} == $past(hwdata[11:0], 2))
    else $error("led current not copied");

  // main scenarios reached
  cover property (led_on == 3'h7);
  cover property ($rose(int_oe));
  cover property ($rose(adc_start) && adc_chan == `PSQ_ALS_CH);
endmodule

bind psq_sequencer psq_assertions psq_assertions_i
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .adc_clk, .adc_done, .adc_start, .adc_chan, .led_on,
  .led_cur0, .led_cur1, .led_cur2, .int_out, .int_oe
);

// ==== bench/psq_adc_model.sv ====
// adc partner: link clock only inside a conversion
`timescale 1ns/1ps

module psq_adc_model
(
  // sequencer side
  input wire adc_start,
  input wire [1:0] adc_chan,
  // bench control
  input wire [11:0] base,
  input wire [3:0] ovf_mask,
  input wire slow,
  // link outputs
  output reg adc_clk,
  output reg adc_done,
  output reg adc_ovf,
  output reg [11:0] adc_data
);
  initial
  begin
    adc_clk = 1'b0;
    adc_done = 1'b0;
    adc_ovf = 1'b0;
    adc_data = 12'hA5A;
  end

  // one conversion; done must be seen at a rising link edge
  always
  begin
    wait (adc_start);
    // keep link edges off the sequencer's clock edges
    #5;
    repeat (slow ? 4 : 1)
    begin
      #100 adc_clk = 1'b1;
      #100 adc_clk = 1'b0;
    end
    adc_data = base + {10'h0, adc_chan};
    adc_ovf = ovf_mask[adc_chan];
    adc_done = 1'b1;
    #100 adc_clk = 1'b1;
    @(negedge adc_start);
    // released lines carry the inverse, not a stale value
    adc_done = 1'b0;
    adc_data = ~adc_data;
    adc_ovf = ~adc_ovf;
    #100 adc_clk = 1'b0;
  end
endmodule

// ==== bench/tb_top.sv ====
// bench for the proximity sequencer: bus host and scenarios
`timescale 1ns/1ps
`include "psq_defines.vh"

module tb_top;
  reg hclk, hresetn, hsel, hwrite, slow, ps;
  reg [31:0] haddr, hwdata, r;
  reg [1:0] htrans;
  reg [11:0] base;
  reg [3:0] ovf_mask;
  reg [4:0] q[$];
  integer n_fail, n_compared;
  wire [31:0] hrdata;
  wire hreadyout, adc_clk, adc_done, adc_ovf, adc_start, int_out, int_oe;
  wire [11:0] adc_data;
  wire [1:0] adc_chan;
  wire [2:0] led_on;
  wire [3:0] led_cur0, led_cur1, led_cur2;
  // open-drain interrupt line with pull-up
  wire int_pin = int_oe ? int_out : 1'b1;

  psq_sequencer psq_sequencer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .adc_clk(adc_clk), .adc_done(adc_done),
    .adc_ovf(adc_ovf), .adc_data(adc_data), .adc_start(adc_start), .adc_chan(adc_chan),
    .led_on(led_on), .led_cur0(led_cur0), .led_cur1(led_cur1), .led_cur2(led_cur2),
    .int_in(int_pin), .int_out(int_out), .int_oe(int_oe));
  psq_adc_model psq_adc_model_i (.adc_start(adc_start), .adc_chan(adc_chan), .base(base),
    .ovf_mask(ovf_mask), .slow(slow), .adc_clk(adc_clk), .adc_done(adc_done),
    .adc_ovf(adc_ovf), .adc_data(adc_data));

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // log each conversion as {channel, leds}
  always @(posedge hclk)
  begin
    if (adc_start && !ps)
      q.push_back({adc_chan, led_on});
    ps <= adc_start;
  end

  // ==========
  // utilities
  task summarize;
  begin
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input [31:0] s, input [31:0] e);
  begin
    n_compared = n_compared + 1;
    if (s !== e)
    begin
      n_fail = n_fail + 1;
      $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
    end
  end
  endtask
  // bounded wait: c=0 bus ready, 1 set over, 2 interrupt low
  task hold(input integer c, input integer n);
    integer k;
  begin
    k = 0;
    @(posedge hclk);
    while (c == 0 ? hreadyout !== 1'b1 : c == 1 ? q.size() < n || adc_start : int_pin !== 1'b0)
    begin
      k = k + 1;
      if (k > 4000)
      begin
        n_fail = n_fail + 1;
        summarize;
      end
      @(posedge hclk);
    end
  end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
  begin
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hold(0, 0);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    hold(0, 0);
    r = hrdata;
  end
  endtask
  task rd(input [7:0] a, input [31:0] e);
  begin
    bus(1'b0, a, 32'h0);
    chk(r, e);
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  // command, then wait for n conversions to finish
  task go(input [7:0] c, input integer n);
  begin
    q.delete();
    wr(`PSQ_A_CMD, {24'h0, c});
    if (n > 0)
      hold(1, n);
    repeat (4) @(posedge hclk);
  end
  endtask

  // ==========
  // scenarios
  task t_reset;
  begin
    rd(`PSQ_A_CFG, 32'h1);
    rd(`PSQ_A_LEDSEL, 32'h421);
    rd(`PSQ_A_LEDCUR, 32'h111);
    rd(`PSQ_A_ISTAT, 32'h0);
    rd(8'h40, 32'h0);
    chk({led_cur2, led_cur1, led_cur0}, 12'h111);
    wr(`PSQ_A_LEDCUR, 32'hA5C);
    repeat (2) @(posedge hclk);
    chk({led_cur2, led_cur1, led_cur0}, 12'hA5C);
  end
  endtask
  task t_force;
  begin
    wr(`PSQ_A_CFG, 32'h7);
    wr(`PSQ_A_IEN, 32'h1);
    go(`PSQ_CMD_PS_FORCE, 3);
    chk(q[0], 5'h01);
    chk(q[1], 5'h0A);
    chk(q[2], 5'h14);
    chk(int_pin, 1'b0);
    rd(`PSQ_A_DATA1, base + 12'h1);
    rd(`PSQ_A_ISTAT, 32'h1);
    wr(`PSQ_A_ICLR, 32'h7);
    @(posedge hclk);
    chk(int_pin, 1'b1);
    go(`PSQ_CMD_ALS_FORCE, 1);
    chk(q[0], 5'h18);
    wr(`PSQ_A_CFG, 32'h5);
    wr(`PSQ_A_LEDSEL, 32'h107);
    go(`PSQ_CMD_PS_FORCE, 2);
    chk(q[0], 5'h07);
    chk(q[1], 5'h11);
    chk(q.size(), 2);
  end
  endtask
  task t_thresh;
  begin
    wr(`PSQ_A_CFG, 32'h9);
    wr(`PSQ_A_TH0, 32'h100);
    wr(`PSQ_A_IEN, 32'h2);
    base <= 12'h050;
    go(`PSQ_CMD_PS_FORCE, 1);
    wr(`PSQ_A_ICLR, 32'h7);
    go(`PSQ_CMD_PS_FORCE, 1);
    chk(int_pin, 1'b1);
    base <= 12'h200;
    go(`PSQ_CMD_PS_FORCE, 1);
    chk(int_pin, 1'b0);
    wr(`PSQ_A_ICLR, 32'h7);
    go(`PSQ_CMD_PS_FORCE, 1);
    chk(int_pin, 1'b1);
  end
  endtask
  task t_ovf;
  begin
    ovf_mask <= 4'h1;
    go(`PSQ_CMD_PS_FORCE, 1);
    rd(`PSQ_A_DATA0, 32'hFFF);
    bus(1'b0, `PSQ_A_RESP, 32'h0);
    chk(r[0], 1'b1);
    ovf_mask <= 4'h0;
    slow <= 1'b1;
    go(`PSQ_CMD_PS_FORCE, 1);
    rd(`PSQ_A_DATA0, 32'h200);
    bus(1'b0, `PSQ_A_RESP, 32'h0);
    chk(r[0], 1'b1);
    go(`PSQ_CMD_NOP, 0);
    bus(1'b0, `PSQ_A_RESP, 32'h0);
    chk(r[0], 1'b0);
    slow <= 1'b0;
  end
  endtask
  task t_auto;
  begin
    wr(`PSQ_A_CFG, 32'h1);
    wr(`PSQ_A_RATE, 32'h2);
    wr(`PSQ_A_IEN, 32'h1);
    go(`PSQ_CMD_AUTO_GO, 0);
    hold(2, 0);
    wr(`PSQ_A_ICLR, 32'h7);
    @(posedge hclk);
    hold(2, 0);
    chk(int_pin, 1'b0);
    go(`PSQ_CMD_AUTO_STOP, 0);
    repeat (100) @(posedge hclk);
    q.delete();
    repeat (300) @(posedge hclk);
    chk(q.size(), 0);
  end
  endtask

  initial
  begin
    n_fail = 0;
    n_compared = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    base = 12'h123;
    ovf_mask = 4'h0;
    slow = 1'b0;
    ps = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_force;
    t_thresh;
    t_ovf;
    t_auto;
    summarize;
  end
endmodule
